// [rtl/ufw_ctrl.sv]
/*
  Power, reset, wake/flush strobe, transmit timeout and parallel I/O
  control of a USB to parallel FIFO bridge, with an AHB-Lite port.
  Assumes the USB engine, FIFO handshake logic and ROM reader sit
  outside and exchange the level and pulse signals below.
*/
`timescale 1ns/1ps
// Behaviour
// - Reset from power-on and external clear
// - Drive clear output from internal reset
// - Supply switch high in suspend or off
// - Bleed option pulls FIFO lines low in suspend or off
// - Strobe in suspend requests resume
// - Strobe outside suspend flushes host data
// - Option bit selects isochronous transfers
// - Timeout flush, 1 to 255 ms
// - Host switches data lines to I/O
// - Bytes presented at prescaled timer rate
// - Return to FIFO mode without reset
// - Built-in defaults without configuration ROM
// - ROM free to others during reset
// - Option selects USB 2.0 descriptor
// - No serial number without valid ROM
// - Clear output low about 5 ms
module ufw_ctrl #(
  parameter int POR_CYC = ufw_pkg::POR_HOLD_CYC,
  parameter int MS_CYC = ufw_pkg::MS_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ext_clear_n,
  output logic por_clear_out_n,
  input wire logic test_mode,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic usb_suspend,
  input wire logic usb_configured,
  input wire logic tx_residual,
  input wire logic tx_activity,
  output logic flush_req,
  output logic resume_req,
  output logic supply_switch_n,
  output logic bleed_pd_en,
  input wire logic flush_wake_strobe,
  input wire logic [7:0] fifo_d_o,
  input wire logic fifo_d_oe,
  output logic [7:0] fifo_d_i,
  output logic bb_active,
  input wire logic [7:0] pin_d_i,
  output logic [7:0] pin_d_o,
  output logic [7:0] pin_d_oe,
  input wire logic cfg_rom_valid,
  input wire ufw_pkg::ufw_cfg_t cfg_rom_opts,
  output logic cfg_rom_release,
  output logic iso_mode,
  output logic usb2_desc,
  output logic serial_num_en
);

  ufw_pkg::ufw_state_t st_reg;
  ufw_pkg::ufw_state_t st_next;
  ufw_pkg::ufw_cfg_t cfg;
  logic [9:0] sync_q;
  logic clr_s;
  logic strobe_s;
  logic [7:0] pin_s;
  logic rst_int;
  logic addr_ok;
  logic stall;
  logic wr_now;
  logic ms_tick;
  logic pre_tick;
  logic strobe_fall;
  logic [31:0] rd_val;

  // Bus write decode and read forwarding
  logic addr_in;
  logic wr_ctrl;
  logic wr_tmo;
  logic wr_presc;
  logic wr_dir;
  logic [7:0] tmo_wval;
  logic bb_en_v;
  logic [7:0] tmo_v;
  logic [15:0] presc_v;
  logic [7:0] dir_v;

  // Pins from outside the clock domain pass two flops
  ufw_sync #(
    .W(10),
    .RST_VAL(10'h3FF)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({ext_clear_n, flush_wake_strobe, pin_d_i}),
    .sync_out(sync_q)
  );

  assign clr_s = sync_q[9];
  assign strobe_s = sync_q[8];
  assign pin_s = sync_q[7:0];

  // Power-on reset or external clear both reset the logic
  assign rst_int = reset | ~clr_s;

  // Options from the ROM only when it reads back valid
  always_comb begin
    if (cfg_rom_valid) begin
      cfg = cfg_rom_opts;
    end else begin
      cfg = ufw_pkg::CFG_DEFAULT;
    end
  end

  // Timebases: millisecond tick and parallel I/O prescaler
  assign ms_tick = st_reg.ms_cnt == 15'(MS_CYC - 1);
  assign pre_tick = st_reg.pre_cnt == st_reg.presc;

  // Synchronised strobe, high-to-low only once per strobe
  assign strobe_fall = st_reg.strobe_q & ~strobe_s;

  // Bus handshake: a data write stalls while a byte waits
  assign stall = st_reg.dph & st_reg.dwr & st_reg.bb_pend &
                 (st_reg.daddr == ufw_pkg::OFS_DATA);
  assign wr_now = st_reg.dph & st_reg.dwr & ~stall;
  assign addr_ok = hsel & htrans[1] & hready;

  // Only the low 32 bytes decode; anything above reads 0, writes drop
  assign addr_in = haddr[31:5] == 27'h0000000;

  // Decode of the write whose data phase ends this cycle
  assign wr_ctrl = wr_now & (st_reg.daddr == ufw_pkg::OFS_CTRL);
  assign wr_tmo = wr_now & (st_reg.daddr == ufw_pkg::OFS_TMO);
  assign wr_presc = wr_now & (st_reg.daddr == ufw_pkg::OFS_PRESC);
  assign wr_dir = wr_now & (st_reg.daddr == ufw_pkg::OFS_DIR);

  // Zero is out of range, clamp to the 1 ms floor
  always_comb begin
    if (hwdata[7:0] == 8'h00) begin
      tmo_wval = ufw_pkg::TMO_MIN;
    end else begin
      tmo_wval = hwdata[7:0];
    end
  end

  // A read right behind a write must see the new value, not the old
  always_comb begin
    bb_en_v = st_reg.bb_en;
    tmo_v = st_reg.tmo;
    presc_v = st_reg.presc;
    dir_v = st_reg.bb_dir;
    if (wr_ctrl) begin
      bb_en_v = hwdata[ufw_pkg::CTRL_BB_EN];
    end
    if (wr_tmo) begin
      tmo_v = tmo_wval;
    end
    if (wr_presc) begin
      presc_v = hwdata[15:0];
    end
    if (wr_dir) begin
      dir_v = hwdata[7:0];
    end
  end

  // Read mux, sampled in the address phase
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr[4:0])
      ufw_pkg::OFS_CTRL: rd_val[ufw_pkg::CTRL_BB_EN] = bb_en_v;
      ufw_pkg::OFS_TMO: rd_val[7:0] = tmo_v;
      ufw_pkg::OFS_PRESC: rd_val[15:0] = presc_v;
      ufw_pkg::OFS_DIR: rd_val[7:0] = dir_v;
      ufw_pkg::OFS_DATA: rd_val[7:0] = pin_s;
      ufw_pkg::OFS_STAT: begin
        rd_val[ufw_pkg::STAT_SUSP] = usb_suspend;
        rd_val[ufw_pkg::STAT_SUPN] = st_reg.sup_n;
        rd_val[ufw_pkg::STAT_PEND] = st_reg.bb_pend;
        rd_val[ufw_pkg::STAT_POR] = st_reg.por_done;
        rd_val[ufw_pkg::STAT_TEST] = test_mode;
        rd_val[ufw_pkg::STAT_PIN +: 8] = pin_s;
      end
      ufw_pkg::OFS_CFG: rd_val[4:0] = {cfg_rom_valid, cfg};
      default: rd_val = 32'h0000_0000;
    endcase
    if (!addr_in) begin
      rd_val = 32'h0000_0000;
    end
  end

  // Next-state function of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.flush = 1'b0;
    st_next.resume = 1'b0;
    st_next.strobe_q = strobe_s;

    // Hold clear out low for the set time after release
    if (!st_reg.por_done) begin
      if (st_reg.por_cnt == 17'(POR_CYC - 1)) begin
        st_next.por_done = 1'b1;
      end else begin
        st_next.por_cnt = st_reg.por_cnt + 17'h00001;
      end
    end

    // Free-running millisecond divider
    if (ms_tick) begin
      st_next.ms_cnt = 15'h0000;
    end else begin
      st_next.ms_cnt = st_reg.ms_cnt + 15'h0001;
    end

    // Bus: capture address phase, apply data phase write
    if (hready) begin
      st_next.dph = addr_ok;
      st_next.dwr = addr_ok & hwrite & addr_in;
      st_next.daddr = haddr[4:0];
      if (addr_ok && !hwrite) begin
        st_next.rdata = rd_val;
      end
    end
    if (wr_now) begin
      unique case (st_reg.daddr)
        ufw_pkg::OFS_CTRL: begin
          st_next.bb_en = hwdata[ufw_pkg::CTRL_BB_EN];
        end
        ufw_pkg::OFS_TMO: begin
          st_next.tmo = tmo_wval;
        end
        ufw_pkg::OFS_PRESC: st_next.presc = hwdata[15:0];
        ufw_pkg::OFS_DIR: st_next.bb_dir = hwdata[7:0];
        ufw_pkg::OFS_DATA: begin
          st_next.bb_byte = hwdata[7:0];
          st_next.bb_pend = 1'b1;
        end
        default: st_next.bb_en = st_reg.bb_en;
      endcase
    end

    // Prescaled pacing of bytes onto the data lines
    if (pre_tick) begin
      st_next.pre_cnt = 16'h0000;
    end else begin
      st_next.pre_cnt = st_reg.pre_cnt + 16'h0001;
    end
    if (st_reg.bb_en && st_reg.bb_pend && pre_tick) begin
      st_next.bb_out = st_reg.bb_byte;
      st_next.bb_pend = 1'b0;
    end
    // Leaving I/O mode drops any byte not yet shown
    if (!st_reg.bb_en) begin
      st_next.bb_pend = wr_now & (st_reg.daddr == ufw_pkg::OFS_DATA);
      st_next.pre_cnt = 16'h0000;
    end

    // Strobe: resume in suspend, flush otherwise
    if (strobe_fall) begin
      if (usb_suspend) begin
        st_next.resume = cfg.remote_wake;
      end else begin
        st_next.flush = 1'b1;
      end
    end

    // Residual host-bound data flushed after timeout
    if (!tx_residual || tx_activity || st_next.flush) begin
      st_next.tmo_cnt = 8'h00;
    end else if (ms_tick) begin
      if (st_reg.tmo_cnt + 8'h01 >= st_reg.tmo) begin
        st_next.flush = 1'b1;
        st_next.tmo_cnt = 8'h00;
      end else begin
        st_next.tmo_cnt = st_reg.tmo_cnt + 8'h01;
      end
    end

    // Supply switch marks suspend and unpowered periphery
    st_next.sup_n = usb_suspend | ~usb_configured;
    st_next.bleed = cfg.bleed_en & st_next.sup_n;

    // Data line drivers; bleeding wins, then I/O mode
    if (st_next.bleed) begin
      st_next.pin_o = 8'h00;
      st_next.pin_oe = 8'h00;
    end else if (st_next.bb_en) begin
      st_next.pin_o = st_next.bb_out;
      st_next.pin_oe = st_next.bb_dir;
    end else begin
      st_next.pin_o = fifo_d_o;
      st_next.pin_oe = {8{fifo_d_oe}};
    end
  end

  // Register update; clear values cover power-on and external clear
  always_ff @(posedge clk) begin
    if (rst_int) begin
      st_reg <= '0;
      st_reg.tmo <= ufw_pkg::TMO_RST;
      st_reg.presc <= ufw_pkg::PRESC_RST;
      st_reg.bb_dir <= ufw_pkg::DIR_RST;
      // Strobe idles high, so no false edge follows a clear
      st_reg.strobe_q <= 1'b1;
      st_reg.sup_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign por_clear_out_n = st_reg.por_done;
  assign cfg_rom_release = ~st_reg.por_done;
  // Wait state only while a byte is still queued
  assign hreadyout = ~stall;
  // Every transfer answers OKAY
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign flush_req = st_reg.flush;
  assign resume_req = st_reg.resume;
  assign supply_switch_n = st_reg.sup_n;
  assign bleed_pd_en = st_reg.bleed;
  // FIFO engine sees the synchronised pins
  assign fifo_d_i = pin_s;
  assign bb_active = st_reg.bb_en;
  assign pin_d_o = st_reg.pin_o;
  assign pin_d_oe = st_reg.pin_oe;
  // Options are read live so a late ROM load still applies
  assign iso_mode = cfg.iso_mode;
  assign usb2_desc = cfg.usb2_desc;
  assign serial_num_en = cfg_rom_valid;

endmodule : ufw_ctrl

// [rtl/ufw_pkg.sv]
/*
  Shared constants and carrier types for the USB FIFO bridge power,
  wake and parallel I/O control block.
  Assumes a single 20 MHz clock and an AHB-Lite register port.
*/
package ufw_pkg;

  // Clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int POR_HOLD_MS = 5;
  localparam int POR_HOLD_CYC = POR_HOLD_MS * (CLK_HZ / 1000);
  localparam int MS_PERIOD_MS = 1;
  localparam int MS_CYC = MS_PERIOD_MS * (CLK_HZ / 1000);

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_TMO = 5'h04;
  localparam logic [4:0] OFS_PRESC = 5'h08;
  localparam logic [4:0] OFS_DIR = 5'h0C;
  localparam logic [4:0] OFS_DATA = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;
  localparam logic [4:0] OFS_CFG = 5'h18;

  // Field positions
  localparam int CTRL_BB_EN = 0;
  localparam int STAT_SUSP = 0;
  localparam int STAT_SUPN = 1;
  localparam int STAT_PEND = 2;
  localparam int STAT_POR = 3;
  localparam int STAT_TEST = 4;
  localparam int STAT_PIN = 8;

  // Reset values and timeout floor
  localparam logic [7:0] TMO_RST = 8'h10;
  localparam logic [7:0] TMO_MIN = 8'h01;
  localparam logic [15:0] PRESC_RST = 16'h0000;
  localparam logic [7:0] DIR_RST = 8'hFF;

  // Options held in the configuration ROM
  typedef struct packed {
    logic usb2_desc;
    logic bleed_en;
    logic iso_mode;
    logic remote_wake;
  } ufw_cfg_t;

  localparam ufw_cfg_t CFG_DEFAULT = '{default: 1'b0};

  // Entire register state of the control block
  typedef struct packed {
    logic bb_en;
    logic [7:0] tmo;
    logic [15:0] presc;
    logic [7:0] bb_dir;
    logic [7:0] bb_byte;
    logic bb_pend;
    logic [7:0] bb_out;
    logic [15:0] pre_cnt;
    logic [14:0] ms_cnt;
    logic [7:0] tmo_cnt;
    logic [16:0] por_cnt;
    logic por_done;
    logic strobe_q;
    logic flush;
    logic resume;
    logic sup_n;
    logic bleed;
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
    logic dph;
    logic dwr;
    logic [4:0] daddr;
    logic [31:0] rdata;
  } ufw_state_t;

endpackage : ufw_pkg

// [rtl/ufw_sync.sv]
/*
  Two-stage synchroniser for a group of asynchronous inputs.
  Assumes the inputs change freely relative to clk.
*/
`timescale 1ns/1ps
module ufw_sync #(
  parameter int W = 10,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ufw_sync_t;

  ufw_sync_t st_reg;
  ufw_sync_t st_next;

  // First stage feeds only the second stage
  always_comb begin
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.s2;

endmodule : ufw_sync

// [verif/ufw_ctrl_monitor.sv]
/*
  Port checker for the power, wake and parallel I/O control block.
  Assumes it is bound to every ufw_ctrl instance, one clock domain.
*/
`timescale 1ns/1ps
module ufw_mon (
  input wire logic clk,
  input wire logic reset,
  input wire logic ext_clear_n,
  input wire logic flush_wake_strobe,
  input wire logic usb_suspend,
  input wire logic usb_configured,
  input wire logic cfg_rom_valid,
  input wire ufw_pkg::ufw_cfg_t cfg_rom_opts,
  input wire logic flush_req,
  input wire logic resume_req,
  input wire logic supply_switch_n,
  input wire logic bleed_pd_en,
  input wire logic iso_mode,
  input wire logic usb2_desc,
  input wire logic serial_num_en,
  input wire logic cfg_rom_release,
  input wire logic por_clear_out_n
);
  logic off;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Suspend or power off, as one level
  assign off = usb_suspend | ~usb_configured;
  // Strobe seen low, then two sync stages and one register
  sequence s_fall;
    $fell(flush_wake_strobe);
  endsequence
  sequence s_wake;
    usb_suspend && cfg_rom_valid && cfg_rom_opts.remote_wake;
  endsequence
  // Clear of either kind has left the registers for a full sync span
  sequence s_run;
    !$past(reset) && $past(ext_clear_n) && $past(ext_clear_n, 2) &&
      $past(ext_clear_n, 3);
  endsequence
  a_strobe_flush: assert property (
    s_fall ##0 !usb_suspend |-> ##3 flush_req) else $error("no flush");
  a_strobe_wake: assert property (
    s_fall ##0 s_wake |-> ##3 resume_req) else $error("no resume");
  a_one_action: assert property (
    flush_req || resume_req |=> !flush_req && !resume_req)
    else $error("action repeated");
  a_wake_suspend: assert property (
    resume_req |-> $past(usb_suspend, 3)) else $error("resume awake");
  a_supply_level: assert property (
    s_run |-> supply_switch_n == $past(off))
    else $error("supply switch wrong");
  a_bleed_off: assert property (
    s_run |-> bleed_pd_en == (supply_switch_n &&
      $past(cfg_rom_valid && cfg_rom_opts.bleed_en)))
    else $error("bleed level wrong");
  a_iso_option: assert property (
    iso_mode == (cfg_rom_valid && cfg_rom_opts.iso_mode))
    else $error("iso mode wrong");
  a_usb2_option: assert property (
    usb2_desc == (cfg_rom_valid && cfg_rom_opts.usb2_desc))
    else $error("descriptor wrong");
  a_serial_rom: assert property (
    serial_num_en == cfg_rom_valid) else $error("serial wrong");
  a_rom_release: assert property (
    cfg_rom_release == !por_clear_out_n) else $error("release wrong");
endmodule : ufw_mon

bind ufw_ctrl ufw_mon u_mon (.clk(clk), .reset(reset),
  .ext_clear_n(ext_clear_n),
  .flush_wake_strobe(flush_wake_strobe), .usb_suspend(usb_suspend),
  .usb_configured(usb_configured), .cfg_rom_valid(cfg_rom_valid),
  .cfg_rom_opts(cfg_rom_opts), .flush_req(flush_req),
  .resume_req(resume_req), .supply_switch_n(supply_switch_n),
  .bleed_pd_en(bleed_pd_en), .iso_mode(iso_mode), .usb2_desc(usb2_desc),
  .serial_num_en(serial_num_en), .cfg_rom_release(cfg_rom_release),
  .por_clear_out_n(por_clear_out_n));

// [verif/ufw_far_model.sv]
/*
  Logic on the parallel side: strobes the flush/wake pin and shares
  the eight data lines. Assumes go is a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
module ufw_far_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] far_val,
  input wire logic [7:0] pin_d_o,
  input wire logic [7:0] pin_d_oe,
  output logic flush_wake_strobe,
  output logic test_mode,
  output logic [7:0] pin_d_i
);
  logic [3:0] low_cnt;
  initial low_cnt = 4'h0;
  // Held low six cycles: a long strobe must still act once
  always @(posedge clk) begin
    if (go)
      low_cnt <= 4'h6;
    else if (low_cnt != 4'h0)
      low_cnt <= low_cnt - 4'h1;
  end
  assign flush_wake_strobe = (low_cnt == 4'h0);
  assign test_mode = 1'b0;
  // Wire level: device bits where enabled, far side elsewhere
  assign pin_d_i = (pin_d_oe & pin_d_o) | (~pin_d_oe & far_val);
endmodule : ufw_far_model

// [verif/ufw_tb_top.sv]
/*
  Self-checking bench for ufw_ctrl with short reset and ms counts.
  Assumes the far-side model and the bound port checker.
*/
`timescale 1ns/1ps
module usb_fifo_power_wake_bitbang_ctrl_tb_top;
  logic clk, reset, ext_clear_n, hsel, hwrite, usb_suspend, go;
  logic usb_configured, tx_residual, tx_activity, cfg_rom_valid;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] far_val, pin_d_i, pin_d_o, pin_d_oe, fifo_d_o, fifo_d_i;
  logic fifo_d_oe;
  ufw_pkg::ufw_cfg_t opts;
  wire hreadyout, flush_req, resume_req, supply_switch_n, bleed_pd_en;
  wire bb_active, por_clear_out_n, test_mode, strobe, cfg_rom_release;
  wire iso_mode, usb2_desc, serial_num_en;
  int errors, total_checks, nflush, nres;

  ufw_ctrl #(.POR_CYC(20), .MS_CYC(10)) u_dut (.clk(clk), .reset(reset),
    .ext_clear_n(ext_clear_n), .por_clear_out_n(por_clear_out_n),
    .test_mode(test_mode), .hsel(hsel), .htrans(htrans), .haddr(haddr),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .usb_suspend(usb_suspend), .usb_configured(usb_configured),
    .tx_residual(tx_residual), .tx_activity(tx_activity),
    .flush_req(flush_req), .resume_req(resume_req),
    .supply_switch_n(supply_switch_n), .bleed_pd_en(bleed_pd_en),
    .flush_wake_strobe(strobe), .fifo_d_o(fifo_d_o), .fifo_d_oe(fifo_d_oe),
    .fifo_d_i(fifo_d_i), .bb_active(bb_active), .pin_d_i(pin_d_i),
    .pin_d_o(pin_d_o), .pin_d_oe(pin_d_oe), .cfg_rom_valid(cfg_rom_valid),
    .cfg_rom_opts(opts), .cfg_rom_release(cfg_rom_release),
    .iso_mode(iso_mode), .usb2_desc(usb2_desc),
    .serial_num_en(serial_num_en));
  ufw_far_model u_far (.clk(clk), .go(go), .far_val(far_val),
    .pin_d_o(pin_d_o), .pin_d_oe(pin_d_oe), .flush_wake_strobe(strobe),
    .test_mode(test_mode), .pin_d_i(pin_d_i));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulse counters, sampled before each edge lands
  always @(posedge clk) begin
    if (flush_req === 1'b1)
      nflush++;
    if (resume_req === 1'b1)
      nres++;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Wait for ready at an edge; only the watchdog ends a hang
  task rdy;
    @(negedge clk);
    while (hreadyout !== 1'b1)
      @(negedge clk);
    @(posedge clk);
  endtask : rdy
  task ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0000000, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : ahb
  task pulse;
    nflush = 0;
    nres = 0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    cyc(15);
  endtask : pulse

  task t_regs;
    ahb(1'b0, ufw_pkg::OFS_TMO, 32'h0);
    chk("tmo", 32'h10, rd);
    ahb(1'b0, ufw_pkg::OFS_DIR, 32'h0);
    chk("dir", 32'hFF, rd);
    ahb(1'b0, ufw_pkg::OFS_CFG, 32'h0);
    chk("cfg", 32'h0, rd);
    ahb(1'b1, 5'h1C, 32'hFFFFFFFF);
    ahb(1'b0, 5'h1C, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, ufw_pkg::OFS_TMO, 32'h0);
    ahb(1'b0, ufw_pkg::OFS_TMO, 32'h0);
    chk("tmo_min", 32'h1, rd);
    $display("test regs done");
  endtask : t_regs

  task t_timeout;
    int n;
    ahb(1'b1, ufw_pkg::OFS_TMO, 32'h2);
    n = 0;
    tx_residual <= 1'b1;
    @(negedge clk);
    while (flush_req !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    tx_residual <= 1'b0;
    chk("tmo_span", 32'h1, 32'(n >= 10 && n <= 24));
    ahb(1'b1, ufw_pkg::OFS_TMO, 32'hFF);
    $display("test timeout done");
  endtask : t_timeout

  task t_power;
    pulse();
    chk("flush", 32'h1, 32'(nflush));
    chk("no_res", 32'h0, 32'(nres));
    usb_suspend <= 1'b1;
    cfg_rom_valid <= 1'b1;
    opts <= ufw_pkg::ufw_cfg_t'(4'hF);
    cyc(4);
    chk("sup_n", 32'h1, 32'(supply_switch_n));
    chk("bleed", 32'h1, 32'(bleed_pd_en));
    chk("serial", 32'h1, 32'(serial_num_en));
    pulse();
    chk("resume", 32'h1, 32'(nres));
    chk("no_flush", 32'h0, 32'(nflush));
    opts <= ufw_pkg::ufw_cfg_t'(4'hE);
    pulse();
    chk("no_wake", 32'h0, 32'(nres));
    usb_suspend <= 1'b0;
    cyc(4);
    chk("sup_on", 32'h0, 32'(supply_switch_n));
    chk("unbleed", 32'h0, 32'(bleed_pd_en));
    usb_configured <= 1'b0;
    cyc(4);
    chk("sup_off", 32'h1, 32'(supply_switch_n));
    usb_configured <= 1'b1;
    cyc(4);
    $display("test power done");
  endtask : t_power

  task t_bitbang;
    int na;
    logic sb;
    na = 0;
    sb = 1'b0;
    ahb(1'b1, ufw_pkg::OFS_PRESC, 32'h3);
    ahb(1'b1, ufw_pkg::OFS_DIR, 32'h0F);
    ahb(1'b1, ufw_pkg::OFS_CTRL, 32'h1);
    fork
      begin
        ahb(1'b1, ufw_pkg::OFS_DATA, 32'hA5);
        ahb(1'b1, ufw_pkg::OFS_DATA, 32'h3C);
      end
      repeat (24) begin
        @(negedge clk);
        if (pin_d_o === 8'hA5)
          na++;
        if (pin_d_o === 8'h3C)
          sb = (na > 0);
      end
    join
    @(posedge clk);
    chk("bb_on", 32'h1, 32'(bb_active));
    chk("hold", 32'h4, 32'(na));
    chk("order", 32'h1, 32'(sb));
    ahb(1'b0, ufw_pkg::OFS_DATA, 32'h0);
    chk("pins", 32'h9C, rd);
    ahb(1'b1, ufw_pkg::OFS_CTRL, 32'h0);
    cyc(2);
    chk("bb_off", 32'h0, 32'(bb_active));
    chk("oe_off", 32'h0, 32'(pin_d_oe));
    fifo_d_o <= 8'h5A;
    fifo_d_oe <= 1'b1;
    cyc(4);
    chk("fifo_o", 32'h5A, 32'(pin_d_o));
    chk("fifo_oe", 32'hFF, 32'(pin_d_oe));
    chk("fifo_in", 32'h5A, 32'(fifo_d_i));
    fifo_d_oe <= 1'b0;
    $display("test bitbang done");
  endtask : t_bitbang

  task t_clear;
    ext_clear_n <= 1'b0;
    cyc(6);
    chk("clr_low", 32'h0, 32'(por_clear_out_n));
    chk("rom_free", 32'h1, 32'(cfg_rom_release));
    ext_clear_n <= 1'b1;
    cyc(30);
    chk("clr_high", 32'h1, 32'(por_clear_out_n));
    ahb(1'b0, ufw_pkg::OFS_TMO, 32'h0);
    chk("tmo_reset", 32'h10, rd);
    $display("test clear done");
  endtask : t_clear

  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // Watchdog: the whole run needs some 200 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    {reset, hsel, hwrite, go, tx_residual, tx_activity} = 6'h20;
    {ext_clear_n, usb_suspend, usb_configured, cfg_rom_valid} = 4'hA;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    far_val = 8'h90;
    fifo_d_o = 8'h00;
    fifo_d_oe = 1'b0;
    opts = ufw_pkg::CFG_DEFAULT;
    cyc(5);
    reset <= 1'b0;
    cyc(1);
    chk("por_low", 32'h0, 32'(por_clear_out_n));
    cyc(18);
    chk("por_hold", 32'h0, 32'(por_clear_out_n));
    cyc(4);
    chk("por_up", 32'h1, 32'(por_clear_out_n));
    t_regs();
    t_timeout();
    t_power();
    t_bitbang();
    t_clear();
    finish_test();
  end
endmodule : usb_fifo_power_wake_bitbang_ctrl_tb_top
